// file: core/swsp_pkg.sv
// shared constants, types and the pulse classifier of the single-wire sensor link
package swsp_pkg;
  localparam int CLK_NS = 5;
  localparam int CNT_W = 18;
  // line timing in ns
  localparam int T_GAP_NS = 11000;
  localparam int T_RST_NS = 354000;
  localparam int T_DET_NS = 9600;
  localparam int T_ZERO_MIN_NS = 11800;
  localparam int T_ZERO_MAX_NS = 17000;
  localparam int T_ONE_MIN_NS = 35400;
  localparam int T_ONE_MAX_NS = 48900;
  localparam int T_START_MIN_NS = 80000;
  localparam int T_START_MAX_NS = 109000;
  localparam int T_STR_MIN_NS = 28300;
  localparam int T_STR_MAX_NS = 38300;
  localparam int T_ATTN_MIN_NS = 165000;
  localparam int T_ATTN_MAX_NS = 228000;
  localparam int T_ATTN_NOM_NS = 196000;
  // derived cycle counts: least times round up, nominals sit mid-window except attention, which takes T_ATTN_NOM_NS
  localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int DET_CYC = T_DET_NS / CLK_NS;
  localparam int ZERO_CYC = (T_ZERO_MIN_NS + T_ZERO_MAX_NS) / 2 / CLK_NS;
  localparam int ONE_CYC = (T_ONE_MIN_NS + T_ONE_MAX_NS) / 2 / CLK_NS;
  localparam int START_CYC = (T_START_MIN_NS + T_START_MAX_NS) / 2 / CLK_NS;
  localparam int STR_CYC = (T_STR_MIN_NS + T_STR_MAX_NS) / 2 / CLK_NS;
  localparam int ATTN_CYC = T_ATTN_NOM_NS / CLK_NS;
  // classification thresholds halfway between neighbouring windows
  localparam int THR_ONE_CYC = (T_ZERO_MAX_NS + T_STR_MIN_NS) / 2 / CLK_NS;
  localparam int THR_START_CYC = (T_ONE_MAX_NS + T_START_MIN_NS) / 2 / CLK_NS;
  localparam int THR_ATTN_CYC = (T_START_MAX_NS + T_ATTN_MIN_NS) / 2 / CLK_NS;
  localparam int THR_RST_CYC = (T_ATTN_MAX_NS + T_RST_NS) / 2 / CLK_NS;
  // frame layout
  localparam int DEV_W = 3;
  localparam int REGN_W = 6;
  localparam int HDR_W = 10;
  localparam int DATA_W = 16;
  localparam int FRAME_W = HDR_W + DATA_W;
  localparam logic [4:0] HDR_LAST = 5'h09;
  localparam logic [4:0] LAST16 = 5'h0F;
  localparam logic [4:0] LAST8 = 5'h07;
  localparam logic [3:0] ATTN_BITS = 4'hE;
  localparam logic [2:0] DEVNUM_RST = 3'h1;
  // slave register numbers
  localparam logic [5:0] REG_DEVNUM = 6'h00;
  localparam logic [5:0] REG_TEMP = 6'h01;
  localparam logic [5:0] REG_MAKER = 6'h02;
  localparam logic [5:0] REG_PART = 6'h03;
  localparam logic [5:0] REG_CAPAB = 6'h04;
  localparam logic [5:0] REG_REV = 6'h20;
  // controller registers on the AHB-Lite side
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_WDATA = 8'h04;
  localparam logic [7:0] A_RDATA = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam int C_GO = 0;
  localparam int C_RW = 1;
  localparam int C_L16 = 2;
  localparam int C_BRST = 3;
  localparam int C_DEV = 8;
  localparam int C_REG = 16;
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_ACK = 2;
  localparam int S_PERR = 3;
  localparam int S_ATTN = 4;
  localparam int S_RSEEN = 5;

  typedef enum logic [2:0] {SYM_ZERO, SYM_ONE, SYM_START, SYM_ATTN, SYM_RST} swsp_sym_t;

  function automatic swsp_sym_t swsp_classify(input logic [CNT_W-1:0] len, input logic [CNT_W-1:0] t1,
                                               input logic [CNT_W-1:0] ts, input logic [CNT_W-1:0] ta,
                                               input logic [CNT_W-1:0] tr);
    if (len < t1) return SYM_ZERO;
    else if (len < ts) return SYM_ONE;
    else if (len < ta) return SYM_START;
    else if (len < tr) return SYM_ATTN;
    else return SYM_RST;
  endfunction
endpackage

// file: core/swsp_link_if.sv
// shared open-drain line between the controller end and the sensor end
`timescale 1ns/100ps
interface swsp_link_if;
  logic slv_out;
  logic slv_oe;
  logic mst_out;
  logic mst_oe;
  logic line;
  // pull-up: the line is low only while an end drives its zero
  assign line = ~((slv_oe & ~slv_out) | (mst_oe & ~mst_out));
  modport slv(input line, output slv_out, output slv_oe);
  modport mst(input line, output mst_out, output mst_oe);
endinterface

// file: core/swsp_slave_end.sv
// sensor end of the single-wire link: pulse decoder, responder and register set
`timescale 1ns/100ps
// Overview of operation
// [RL1] line idle 11 us before any signal
// [RL2] reset pulse lasts at least 354 us
// [RL3] slave sees master falling edge within 9.6 us
// [RL4] master zero and read bits 11.8-17 us
// [RL5] master one bit 35.4-48.9 us
// [RL6] master start pulse 80-109 us
// [RL7] slave returns one by 28.3-38.3 us stretch
// [RL8] slave returns zero by leaving line alone
// [RL9] open-drain drive low only, pull-up high
// [RL10] two strap pins choose four addresses
// [RL11] device number is strap value plus one
// [RL12] answer only a matching device number
// [RL13] resample straps each conversion and transaction
// [RL14] temperature LSB worth 0.25 degrees
// [RL15] readable identity and capability registers
// [RL16] slave may request attention, 196 us low
// [RL17] master starts every data bit
// [RL18] no attention before 14 bits after reset
// [RL19] classify low pulses by width thresholds
// [RL20] synchronise line input, release when idle
module swsp_slave_end
  import swsp_pkg::*;
#(
  parameter logic [CNT_W-1:0] THR_ONE = CNT_W'(THR_ONE_CYC),
  parameter logic [CNT_W-1:0] THR_START = CNT_W'(THR_START_CYC),
  parameter logic [CNT_W-1:0] THR_ATTN = CNT_W'(THR_ATTN_CYC),
  parameter logic [CNT_W-1:0] THR_RST = CNT_W'(THR_RST_CYC),
  parameter logic [CNT_W-1:0] STR_LEN = CNT_W'(STR_CYC),
  parameter logic [CNT_W-1:0] ATTN_LEN = CNT_W'(ATTN_CYC),
  parameter logic [CNT_W-1:0] RST_LEN = CNT_W'(RST_CYC),
  parameter logic [CNT_W-1:0] GAP_LEN = CNT_W'(GAP_CYC),
  // identity values are arbitrary
  parameter logic [15:0] MAKER_ID = 16'h1234,
  parameter logic [15:0] PART_ID = 16'h5678,
  parameter logic [7:0] REVISION = 8'h01,
  parameter logic [7:0] CAPAB = 8'h01
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  swsp_link_if.slv link,
  // straps and sensor
  input wire logic addr_strap_lo,
  input wire logic addr_strap_hi,
  input wire logic conv_start,
  input wire logic [9:0] temp_code,
  input wire logic attn_req,
  // user side results
  output logic wr_valid,
  output logic [5:0] wr_reg,
  output logic [15:0] wr_data,
  output logic attn_pending,
  output logic bus_reset
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_DATA = 3'b011,
    ST_PAR = 3'b010,
    ST_ACK = 3'b110,
    ST_SKIP = 3'b111
  } swsp_st_t;

  logic line_s1_q, line_s2_q, line_d_q;
  logic [CNT_W-1:0] low_cnt_q, hi_cnt_q, drv_cnt_q;
  logic drv_q, por_pend_q, attn_pend_q, init_q;
  logic [3:0] bits_q;
  logic [2:0] dev_num_q;
  logic [9:0] hdr_q;
  logic [15:0] sh_q, rd_val;
  logic [4:0] idx_q;
  logic rw_q, len16_q, par_q;
  logic [5:0] reg_q;
  swsp_st_t st_q;
  logic fall, rise, gap_ok, brst, bit_b, stretch, is8;
  logic [9:0] nh;
  swsp_sym_t sym;

  // the line is only ever pulled low, never driven high
  assign link.slv_out = 1'b0; // RL9
  assign link.slv_oe = drv_q; // RL9 RL20

  // two-stage synchroniser, then edge and width measurement on the second stage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      line_d_q <= 1'b1;
    end
    else
    begin
      line_s1_q <= link.line; // RL20
      line_s2_q <= line_s1_q;
      line_d_q <= line_s2_q;
    end
  end

  // two cycles of latency, far below the detection limit
  assign fall = line_d_q & ~line_s2_q; // RL3
  assign rise = ~line_d_q & line_s2_q;
  assign gap_ok = hi_cnt_q >= GAP_LEN; // RL1
  assign brst = ~line_s2_q && (low_cnt_q == THR_RST - 1'b1); // RL19
  assign sym = swsp_classify(low_cnt_q, THR_ONE, THR_START, THR_ATTN, THR_RST); // RL19
  assign bit_b = (sym == SYM_ONE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      low_cnt_q <= '0;
      hi_cnt_q <= '0;
    end
    else
    begin
      low_cnt_q <= line_s2_q ? '0 : (low_cnt_q == '1 ? low_cnt_q : low_cnt_q + 1'b1);
      hi_cnt_q <= !line_s2_q ? '0 : (gap_ok ? hi_cnt_q : hi_cnt_q + 1'b1);
    end
  end

  // stretch only for slave-supplied ones; a zero leaves the line alone
  always_comb
  begin
    unique case (st_q)
      ST_DATA: stretch = rw_q & sh_q[DATA_W-1]; // RL7 RL8
      ST_PAR: stretch = rw_q & par_q; // RL7 RL8
      ST_ACK: stretch = ~rw_q & ~par_q; // RL7 RL8
      default: stretch = 1'b0;
    endcase
  end

  // drive unit: power-up reset, bit stretch and attention share one counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drv_q <= 1'b0;
      drv_cnt_q <= '0;
      por_pend_q <= 1'b1;
      attn_pend_q <= 1'b0;
    end
    else
    begin
      if (drv_q)
      begin
        drv_cnt_q <= drv_cnt_q - 1'b1;
        if (drv_cnt_q == CNT_W'(1))
          drv_q <= 1'b0;
      end
      else if (fall && stretch)
      begin
        // the master started this bit; the stretch follows its edge
        drv_q <= 1'b1; // RL7 RL17
        drv_cnt_q <= STR_LEN; // RL7
      end
      else if (por_pend_q && line_s2_q && gap_ok)
      begin
        drv_q <= 1'b1; // RL1
        drv_cnt_q <= RST_LEN; // RL2
        por_pend_q <= 1'b0;
      end
      else if (attn_pend_q && !por_pend_q && line_s2_q && gap_ok && bits_q >= ATTN_BITS && st_q == ST_IDLE)
      begin
        drv_q <= 1'b1; // RL16 RL18
        drv_cnt_q <= ATTN_LEN; // RL16
        attn_pend_q <= 1'b0;
      end
      // a request in the launch cycle stays pending
      if (attn_req)
        attn_pend_q <= 1'b1;
    end
  end

  assign attn_pending = attn_pend_q;

  // device number follows the straps at every conversion and transaction start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dev_num_q <= DEVNUM_RST;
      init_q <= 1'b1;
    end
    else
    begin
      init_q <= 1'b0;
      if (init_q || conv_start || (rise && sym == SYM_START))
        dev_num_q <= {1'b0, addr_strap_hi, addr_strap_lo} + DEVNUM_RST; // RL10 RL11 RL13
    end
  end

  // read view: eight-bit registers are left-justified so their MSB leaves first
  always_comb
  begin
    nh = {hdr_q[8:0], bit_b};
    unique case (nh[6:1])
      REG_DEVNUM: rd_val = {5'h00, dev_num_q, 8'h00}; // RL11
      REG_TEMP: rd_val = {temp_code, 6'h00}; // RL14
      REG_MAKER: rd_val = MAKER_ID; // RL15
      REG_PART: rd_val = PART_ID; // RL15
      REG_CAPAB: rd_val = {CAPAB, 8'h00}; // RL15
      REG_REV: rd_val = {REVISION, 8'h00}; // RL15
      default: rd_val = 16'h0000;
    endcase
    is8 = (nh[6:1] == REG_DEVNUM) || (nh[6:1] == REG_CAPAB) || (nh[6:1] == REG_REV);
  end

  // frame decoder
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= ST_IDLE;
      idx_q <= '0;
      hdr_q <= '0;
      sh_q <= '0;
      par_q <= 1'b0;
      rw_q <= 1'b0;
      len16_q <= 1'b0;
      reg_q <= '0;
      bits_q <= '0;
    end
    else if (brst)
    begin
      // abandon the frame; registers keep their contents
      st_q <= ST_IDLE;
      bits_q <= '0; // RL18
    end
    else if (rise && sym == SYM_START)
    begin
      st_q <= ST_HDR; // RL6
      idx_q <= '0;
      par_q <= 1'b0;
    end
    else if (rise && (sym == SYM_ZERO || sym == SYM_ONE))
    begin
      if (bits_q != ATTN_BITS)
        bits_q <= bits_q + 1'b1; // RL18
      par_q <= par_q ^ bit_b;
      idx_q <= idx_q + 1'b1;
      unique case (st_q)
        ST_HDR:
        begin
          hdr_q <= nh;
          if (idx_q == HDR_LAST)
          begin
            idx_q <= '0;
            rw_q <= nh[0];
            reg_q <= nh[6:1];
            len16_q <= ~is8;
            sh_q <= rd_val;
            st_q <= (nh[9:7] == dev_num_q) ? ST_DATA : ST_SKIP; // RL12
          end
        end
        ST_DATA:
        begin
          sh_q <= {sh_q[DATA_W-2:0], bit_b};
          if (idx_q == (len16_q ? LAST16 : LAST8))
            st_q <= ST_PAR;
        end
        ST_PAR: st_q <= ST_ACK;
        ST_ACK: st_q <= ST_IDLE;
        ST_IDLE, ST_SKIP: st_q <= st_q;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // a write is passed on once its parity checked good and its acknowledge ended
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_valid <= 1'b0;
      wr_reg <= '0;
      wr_data <= '0;
      bus_reset <= 1'b0;
    end
    else
    begin
      bus_reset <= brst;
      wr_valid <= rise && (sym == SYM_ZERO || sym == SYM_ONE) && st_q == ST_ACK && !rw_q && !par_q && !brst;
      if (rise && st_q == ST_ACK && !rw_q && !par_q)
      begin
        wr_reg <= reg_q;
        wr_data <= sh_q;
      end
    end
  end
endmodule // swsp_slave_end

// file: core/swsp_master_end.sv
// controller end of the single-wire link with an AHB-Lite register port
`timescale 1ns/100ps
module swsp_master_end
  import swsp_pkg::*;
#(
  parameter logic [CNT_W-1:0] ONE_LEN = CNT_W'(ONE_CYC),
  parameter logic [CNT_W-1:0] START_LEN = CNT_W'(START_CYC),
  parameter logic [CNT_W-1:0] RST_LEN = CNT_W'(RST_CYC),
  parameter logic [CNT_W-1:0] THR_ONE = CNT_W'(THR_ONE_CYC),
  parameter logic [CNT_W-1:0] THR_ATTN = CNT_W'(THR_ATTN_CYC),
  parameter logic [CNT_W-1:0] THR_RST = CNT_W'(THR_RST_CYC),
  parameter logic [CNT_W-1:0] GAP_LEN = CNT_W'(GAP_CYC)
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // link
  swsp_link_if.mst link
);
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_GAP = 2'b01, M_DRIVE = 2'b11, M_WAIT = 2'b10} swsp_mst_t;

  localparam logic [CNT_W-1:0] ZERO_LEN = CNT_W'(ZERO_CYC);
  logic ap_v_q, ap_wr_q;
  logic [7:0] ap_addr_q;
  logic rw_q, l16_q, go_q, brst_q, por_q, rjob_q, busy_q;
  logic done_q, ack_q, perr_q, attn_q, rseen_q, par_q, drv_q, s1_q, s2_q, d_q;
  logic [2:0] dev_q;
  logic [5:0] regn_q;
  logic [15:0] wdata_q, rd_q;
  logic [FRAME_W-1:0] sh_q;
  logic [4:0] idx_q, last_idx, par_idx;
  logic [CNT_W-1:0] cnt_q, low_q, hi_q, plen;
  swsp_mst_t st_q;
  logic wr_en, rise, b, smp, tx, stat_w;
  logic [31:0] stat;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = ap_v_q & ap_wr_q;
  assign stat_w = wr_en && ap_addr_q == A_STAT;
  assign stat = 32'({rseen_q, attn_q, perr_q, ack_q, done_q, busy_q});

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_v_q <= 1'b0;
      ap_wr_q <= 1'b0;
      ap_addr_q <= '0;
      hrdata <= '0;
    end
    else
    begin
      ap_v_q <= hsel & hready & htrans[1];
      ap_wr_q <= hwrite;
      ap_addr_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
        unique case (haddr[7:0])
          A_CTRL: hrdata <= 32'({regn_q, 5'h00, dev_q, 5'h00, l16_q, rw_q, 1'b0});
          A_WDATA: hrdata <= 32'(wdata_q);
          A_RDATA: hrdata <= 32'(rd_q);
          A_STAT: hrdata <= stat;
          default: hrdata <= '0;
        endcase
    end
  end

  assign link.mst_out = 1'b0; // RL9
  assign link.mst_oe = drv_q; // RL9

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      d_q <= 1'b1;
      low_q <= '0;
      hi_q <= '0;
    end
    else
    begin
      s1_q <= link.line;
      s2_q <= s1_q;
      d_q <= s2_q;
      low_q <= s2_q ? '0 : (low_q == '1 ? low_q : low_q + 1'b1);
      hi_q <= !s2_q ? '0 : (hi_q >= GAP_LEN ? hi_q : hi_q + 1'b1);
    end
  end

  assign rise = ~d_q & s2_q;
  assign b = low_q >= THR_ONE;
  assign last_idx = l16_q ? 5'h1C : 5'h14;
  assign par_idx = last_idx - 5'h01;

  // which bits the slave supplies and what the master sends otherwise
  always_comb
  begin
    smp = (idx_q > 5'h0A) && (rw_q ? idx_q != last_idx : idx_q == last_idx);
    tx = (idx_q == par_idx) ? par_q : (idx_q == last_idx ? ~par_q : sh_q[FRAME_W-1]);
    if (rjob_q)
      plen = RST_LEN; // RL2
    else if (idx_q == 5'h00)
      plen = START_LEN; // RL6
    else
      plen = (tx && !smp) ? ONE_LEN : ZERO_LEN; // RL4 RL5
  end

  // registers and engine; hardware sets win over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= M_IDLE;
      {rw_q, l16_q, go_q, brst_q, rjob_q, busy_q, drv_q, par_q} <= '0;
      {done_q, ack_q, perr_q, attn_q, rseen_q} <= '0;
      por_q <= 1'b1;
      dev_q <= '0;
      regn_q <= '0;
      wdata_q <= '0;
      rd_q <= '0;
      sh_q <= '0;
      idx_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (wr_en && ap_addr_q == A_CTRL)
      begin
        rw_q <= hwdata[C_RW];
        l16_q <= hwdata[C_L16];
        dev_q <= hwdata[C_DEV +: DEV_W];
        regn_q <= hwdata[C_REG +: REGN_W];
        go_q <= hwdata[C_GO] | go_q;
        brst_q <= hwdata[C_BRST] | brst_q;
      end
      if (wr_en && ap_addr_q == A_WDATA)
        wdata_q <= hwdata[15:0];
      if (stat_w)
      begin
        done_q <= done_q & ~hwdata[S_DONE];
        attn_q <= attn_q & ~hwdata[S_ATTN];
        rseen_q <= rseen_q & ~hwdata[S_RSEEN];
      end
      if (rise && low_q >= THR_RST)
        rseen_q <= 1'b1;
      else if (rise && low_q >= THR_ATTN)
        attn_q <= 1'b1;
      unique case (st_q)
        M_IDLE:
          if (por_q || brst_q)
          begin
            rjob_q <= 1'b1;
            por_q <= 1'b0;
            brst_q <= 1'b0;
            st_q <= M_GAP;
          end
          else if (go_q)
          begin
            go_q <= 1'b0;
            busy_q <= 1'b1;
            idx_q <= '0;
            par_q <= 1'b0;
            sh_q <= {dev_q, regn_q, rw_q, l16_q ? wdata_q : {wdata_q[7:0], 8'h00}};
            st_q <= M_GAP;
          end
        M_GAP:
          if (s2_q && hi_q >= GAP_LEN)
          begin
            drv_q <= 1'b1; // RL1 RL17
            cnt_q <= plen;
            st_q <= M_DRIVE;
          end
        M_DRIVE:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == CNT_W'(1))
          begin
            drv_q <= 1'b0;
            st_q <= M_WAIT;
          end
        end
        M_WAIT:
          if (rise)
          begin
            if (rjob_q || low_q >= THR_RST)
            begin
              rjob_q <= 1'b0;
              done_q <= busy_q;
              busy_q <= 1'b0;
              st_q <= M_IDLE;
            end
            else if (low_q >= THR_ATTN)
              st_q <= M_GAP;
            else
            begin
              // an attention that stretched this bit makes it go again
              st_q <= (idx_q == last_idx) ? M_IDLE : M_GAP;
              idx_q <= idx_q + 5'h01;
              if (idx_q != 5'h00)
              begin
                par_q <= par_q ^ (smp ? b : tx);
                sh_q <= {sh_q[FRAME_W-2:0], 1'b0};
              end
              if (smp && idx_q < par_idx)
                rd_q <= {rd_q[14:0], b};
              if (idx_q == par_idx)
                perr_q <= rw_q & (par_q ^ b);
              if (idx_q == last_idx)
              begin
                ack_q <= smp ? b : tx;
                done_q <= 1'b1;
                busy_q <= 1'b0;
              end
            end
          end
      endcase
    end
  end
endmodule // swsp_master_end

// file: test/swsp_link_sva.sv
// line-level checks on the link between the controller end and the sensor end
`timescale 1ns/100ps
module swsp_link_sva
  import swsp_pkg::*;
#(
  parameter int ONE_LEN = ONE_CYC,
  parameter int START_LEN = START_CYC,
  parameter int STR_LEN = STR_CYC,
  parameter int ATTN_LEN = ATTN_CYC,
  parameter int RST_LEN = RST_CYC,
  parameter int THR_RST = THR_RST_CYC,
  parameter int GAP_LEN = GAP_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // line and both drivers
  input wire logic slv_out,
  input wire logic slv_oe,
  input wire logic mst_out,
  input wire logic mst_oe,
  input wire logic line
);
  logic [17:0] hi_q, lo_q, mlo_q, slo_q, bits_q;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // run lengths of the raw line and of each driver
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) hi_q <= '0;
    else hi_q <= line ? hi_q + 18'h1 : 18'h0;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) lo_q <= '0;
    else lo_q <= line ? 18'h0 : lo_q + 18'h1;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) mlo_q <= '0;
    else mlo_q <= mst_oe ? mlo_q + 18'h1 : 18'h0;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) slo_q <= '0;
    else slo_q <= slv_oe ? slo_q + 18'h1 : 18'h0;
  // controller pulses since the last bus reset; a controller reset pulse itself adds one, which is harmless
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) bits_q <= '0;
    else if (lo_q == 18'(THR_RST)) bits_q <= '0;
    else if (mlo_q != 18'h0 && !mst_oe) bits_q <= bits_q + 18'h1;

  a_mst_low_only: assert property (mst_oe |-> !mst_out)
    else $error("controller drove the line high");
  a_slv_low_only: assert property (slv_oe |-> !slv_out)
    else $error("sensor drove the line high");
  a_mst_idle_gap: assert property ($rose(mst_oe) |-> hi_q >= 18'(GAP_LEN))
    else $error("controller started a pulse too soon");
  a_slv_idle_gap: assert property ($rose(slv_oe) && $past(line) |-> hi_q >= 18'(GAP_LEN))
    else $error("sensor started a pulse too soon");
  a_mst_pulse_len: assert property ($fell(mst_oe) |-> mlo_q inside {[ZERO_CYC-1:ZERO_CYC+1],
    [ONE_LEN-1:ONE_LEN+1], [START_LEN-1:START_LEN+1], [RST_LEN-1:RST_LEN+1]})
    else $error("controller pulse width off");
  a_slv_pulse_len: assert property ($fell(slv_oe) |-> slo_q inside {[STR_LEN-1:STR_LEN+1],
    [ATTN_LEN-1:ATTN_LEN+1], [RST_LEN-1:RST_LEN+1]})
    else $error("sensor pulse width off");
  a_slv_edge_seen: assert property ($rose(slv_oe) && !$past(line) |-> lo_q inside {[2:4]})
    else $error("sensor stretch began late");
  a_attn_after_bits: assert property ($fell(slv_oe) && slo_q inside {[ATTN_LEN-1:ATTN_LEN+1]}
    |-> bits_q >= 18'hE)
    else $error("attention before enough bits");

  c_stretch: cover property ($fell(slv_oe) && slo_q inside {[STR_LEN-1:STR_LEN+1]});
  c_attn: cover property ($fell(slv_oe) && slo_q inside {[ATTN_LEN-1:ATTN_LEN+1]});
  c_start: cover property ($fell(mst_oe) && mlo_q inside {[START_LEN-1:START_LEN+1]});
endmodule // swsp_link_sva

// file: test/testbench.sv
// self-checking bench: controller and sensor ends joined on one line
`timescale 1ns/100ps
module testbench
  import swsp_pkg::*;
;
  // shortened widths; zero pulses keep their full length, so THR1 stays above them
  localparam logic [17:0] THR1 = 18'hDAC;
  localparam logic [17:0] THRS = 18'h125C;
  localparam logic [17:0] THRA = 18'h1770;
  localparam logic [17:0] THRR = 18'h1B58;
  localparam logic [17:0] STR = 18'hFA0;
  localparam logic [17:0] ATT = 18'h1964;
  localparam logic [17:0] RST = 18'h1D4C;
  localparam logic [17:0] ONE = 18'h1068;
  localparam logic [17:0] START = 18'h1388;
  localparam logic [17:0] GAP = 18'h14;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hrdy, hresp, attn_pending, bus_reset, so_q, wr_valid;
  logic [31:0] hrdata;
  logic strap_lo = 1'b1;
  logic strap_hi = 1'b1;
  logic conv_start = 1'b0;
  logic attn_req = 1'b0;
  logic [9:0] temp_code = 10'h0;
  int miscompares = 0;
  int tests_run = 0;
  int n_str = 0;
  int n_brst = 0;
  int n_wr = 0;

  always #2.5 hclk = ~hclk;
  swsp_link_if lk ();
  swsp_master_end #(.ONE_LEN(ONE), .START_LEN(START), .RST_LEN(RST), .THR_ONE(THR1), .THR_ATTN(THRA),
    .THR_RST(THRR), .GAP_LEN(GAP)) i_swsp_master_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .link(lk.mst));
  swsp_slave_end #(.THR_ONE(THR1), .THR_START(THRS), .THR_ATTN(THRA), .THR_RST(THRR), .STR_LEN(STR),
    .ATTN_LEN(ATT), .RST_LEN(RST), .GAP_LEN(GAP)) i_swsp_slave_end (.hclk(hclk), .hresetn(hresetn),
    .link(lk.slv), .addr_strap_lo(strap_lo), .addr_strap_hi(strap_hi), .conv_start(conv_start),
    .temp_code(temp_code), .attn_req(attn_req), .wr_valid(wr_valid), .wr_reg(), .wr_data(),
    .attn_pending(attn_pending), .bus_reset(bus_reset));
  swsp_link_sva #(.ONE_LEN(ONE), .START_LEN(START), .STR_LEN(STR), .ATTN_LEN(ATT), .RST_LEN(RST),
    .THR_RST(THRR), .GAP_LEN(GAP)) i_swsp_link_sva (.hclk(hclk), .hresetn(hresetn), .slv_out(lk.slv_out),
    .slv_oe(lk.slv_oe), .mst_out(lk.mst_out), .mst_oe(lk.mst_oe), .line(lk.line));

  // a sensor stretch is a sensor pull that begins while the controller already holds the line
  always @(posedge hclk)
  begin
    so_q <= lk.slv_oe;
    if (lk.slv_oe === 1'b1 && so_q === 1'b0 && lk.mst_oe === 1'b1) n_str++;
    if (bus_reset === 1'b1) n_brst++;
    if (wr_valid === 1'b1) n_wr++;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic stop(input string m);
    miscompares++;
    $display("CHECK FAILED at %0t: %s timed out", $time, m);
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdy_wait();
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hrdy !== 1'b1 && i < 50);
    if (hrdy !== 1'b1) stop("bus");
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy_wait();
    rd = hrdata;
  endtask
  task automatic poll(input int b);
    logic [31:0] s;
    int i;
    for (i = 0; i < 400; i++)
    begin
      ahb(1'b0, A_STAT, 32'h0, s);
      if (s[b] === 1'b1) return;
      repeat (250) @(posedge hclk);
    end
    stop("status");
  endtask
  task automatic idle_wait();
    int i, n;
    n = 0;
    for (i = 0; i < 40000 && n < 100; i++)
    begin
      @(posedge hclk);
      n = (lk.line === 1'b1) ? n + 1 : 0;
    end
    if (n < 100) stop("idle line");
  endtask
  // read of register 0: parity over dev, read flag and data (= dev) is 1, so one extra stretch
  function automatic logic [31:0] exp_str(input logic [2:0] d);
    return 32'($countones(d)) + 32'h1;
  endfunction

  initial
  begin
    logic [31:0] rd;
    logic [1:0] s;
    logic [2:0] d;
    int nb;
    void'($urandom(64));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    idle_wait();
    ahb(1'b0, A_STAT, 32'h0, rd);
    chk({31'h0, rd[S_RSEEN]}, 32'h1, "reset seen");
    chk({31'h0, n_brst != 0}, 32'h1, "sensor bus reset");
    attn_req <= 1'b1;
    s = 2'($urandom() % 3);
    d = {1'b0, s} + 3'h1;
    @(posedge hclk);
    attn_req <= 1'b0;
    strap_lo <= s[0];
    strap_hi <= s[1];
    temp_code <= 10'($urandom());
    @(posedge hclk);
    conv_start <= 1'b1;
    @(posedge hclk);
    conv_start <= 1'b0;
    chk({31'h0, attn_pending}, 32'h1, "attention held back");
    ahb(1'b1, 8'h10, $urandom(), rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    n_str = 0;
    ahb(1'b1, A_CTRL, (32'(d) << C_DEV) | 32'h3, rd);
    ahb(1'b0, A_CTRL, 32'h0, rd);
    chk(rd, (32'(d) << C_DEV) | 32'h2, "ctrl readback");
    poll(S_DONE);
    ahb(1'b0, A_RDATA, 32'h0, rd);
    chk(rd, 32'(d), "device number");
    chk(32'(n_str), exp_str(d), "sensor stretches");
    chk(32'(n_wr), 32'h0, "write pulses");
    ahb(1'b0, A_STAT, 32'h0, rd);
    chk({30'h0, rd[3:2]}, 32'h1, "ack and parity");
    poll(S_ATTN);
    chk({31'h0, attn_pending}, 32'h0, "attention sent");
    ahb(1'b1, A_STAT, 32'h32, rd);
    ahb(1'b0, A_STAT, 32'h0, rd);
    chk(rd & 32'h33, 32'h0, "status cleared");
    nb = n_brst;
    ahb(1'b1, A_CTRL, 32'h8, rd);
    poll(S_RSEEN);
    idle_wait();
    chk(32'(n_brst), 32'(nb + 1), "requested bus reset");
    wrap_up();
  end
endmodule // testbench
